// >>> rtl/upp_top.sv
// Port power polarity and upstream attach detect, top level
`timescale 1ns/1ps
module upp_top (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Upstream side
  input wire logic upstream_bus_power_sense,
  output logic upstream_dp_pullup_en,
  // Strap
  input wire logic port_power_polarity_strap,
  // Port power requests from the hub core, index 0 is port 2
  input wire logic [upp_pkg::UPP_NPORTS-1:0] port_power_req,
  // Downstream power switches, index 0 is port 2
  output logic [upp_pkg::UPP_NPORTS-1:0] downstream_port_power_enable,
  // Status
  output logic polarity_active_high
);
  import upp_pkg::*;
  // ****************************************
  // Strap capture
  // ****************************************
  logic pol_r;
  logic in_reset_r;
  always_ff @(posedge clk) begin
    if (reset) begin
      in_reset_r <= 1'h1;
    end else begin
      in_reset_r <= 1'h0;
    end
  end
  // Sample on the first clock after release, then freeze
  always_ff @(posedge clk) begin
    if (reset) begin
      pol_r <= UPP_POL_RST;
    end else if (in_reset_r) begin
      pol_r <= port_power_polarity_strap;
    end
  end
  wire logic pol_eff;
  assign pol_eff = in_reset_r ? port_power_polarity_strap : pol_r;
  assign polarity_active_high = pol_r;
  // ****************************************
  // Upstream attach detect
  // ****************************************
  upp_attach_e state_r;
  upp_attach_e state_nxt;
  logic [UPP_FILT_W-1:0] filt_r;
  logic [UPP_FILT_W-1:0] filt_nxt;
  logic pullup_r;
  wire logic filt_done;
  assign filt_done = (filt_r == UPP_FILT_MAX);
  always_comb begin
    state_nxt = state_r;
    filt_nxt = filt_r;
    case (state_r)
      UPP_DETACHED: begin
        if (!upstream_bus_power_sense) begin
          filt_nxt = UPP_FILT_ZERO;
        end else if (filt_done) begin
          state_nxt = UPP_ATTACHED;
        end else begin
          filt_nxt = filt_r + UPP_FILT_ONE;
        end
      end
      UPP_ATTACHED: begin
        filt_nxt = UPP_FILT_ZERO;
        if (!upstream_bus_power_sense) begin
          state_nxt = UPP_DETACHED;
        end
      end
      default: begin
        state_nxt = UPP_DETACHED;
        filt_nxt = UPP_FILT_ZERO;
      end
    endcase
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= UPP_DETACHED;
      filt_r <= UPP_FILT_ZERO;
      pullup_r <= UPP_PULLUP_RST;
    end else begin
      state_r <= state_nxt;
      filt_r <= filt_nxt;
      pullup_r <= (state_nxt == UPP_ATTACHED) && upstream_bus_power_sense;
    end
  end
  // Drop the pull-up at once when bus power goes away
  assign upstream_dp_pullup_en = pullup_r && upstream_bus_power_sense;
  // ****************************************
  // Downstream port power
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < UPP_NPORTS; g++) begin : g_port
      upp_port_drv u_drv (
        .clk(clk),
        .reset(reset),
        .power_req(port_power_req[g]),
        .polarity_live(port_power_polarity_strap),
        .polarity_held(pol_eff),
        .downstream_port_power_enable(downstream_port_power_enable[g])
      );
    end
  endgenerate
endmodule

// >>> rtl/upp_pkg.sv
// Package: constants for the port power and attach detect block
package upp_pkg;
  // ****************************************
  // Port numbering
  // ****************************************
  localparam int unsigned UPP_PORT_LO = 2;
  localparam int unsigned UPP_PORT_HI = 4;
  localparam int unsigned UPP_NPORTS = UPP_PORT_HI - UPP_PORT_LO + 1;
  // ****************************************
  // Reset values and strap encodings
  // ****************************************
  localparam logic UPP_POL_HIGH = 1'h1;
  localparam logic UPP_POL_RST = UPP_POL_HIGH;
  localparam logic UPP_REQ_RST = 1'h0;
  localparam logic UPP_PULLUP_RST = 1'h0;
  // Sense input must be stable this many cycles plus one (5 clocks) before a connect
  localparam int unsigned UPP_SENSE_FILT = 4;
  localparam int unsigned UPP_FILT_W = 3;
  localparam logic [UPP_FILT_W-1:0] UPP_FILT_ZERO = 3'h0;
  localparam logic [UPP_FILT_W-1:0] UPP_FILT_ONE = 3'h1;
  localparam logic [UPP_FILT_W-1:0] UPP_FILT_MAX =
    UPP_FILT_W'(UPP_SENSE_FILT);
  typedef enum logic {UPP_DETACHED, UPP_ATTACHED} upp_attach_e;
endpackage

// >>> rtl/upp_port_drv.sv
// One downstream port power enable output stage
`timescale 1ns/1ps
module upp_port_drv (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Control
  input wire logic power_req,
  input wire logic polarity_live,
  input wire logic polarity_held,
  // Pin
  output logic downstream_port_power_enable
);
  import upp_pkg::*;
  logic req_r;
  wire logic active_level;
  always_ff @(posedge clk) begin
    if (reset) begin
      req_r <= UPP_REQ_RST;
    end else begin
      req_r <= power_req;
    end
  end
  // During reset the live strap sets the level, combinationally
  assign active_level = reset ? polarity_live : polarity_held;
  // Asserted drives the strap level, negated drives its inverse
  assign downstream_port_power_enable =
    (req_r && !reset) ? active_level : ~active_level;
endmodule

// >>> dv/upp_asserts.sv
// Checker for the port power block
`timescale 1ns/1ps
module upp_asserts (
  input wire logic clk,
  input wire logic reset,
  input wire logic upstream_bus_power_sense,
  input wire logic upstream_dp_pullup_en,
  input wire logic port_power_polarity_strap,
  input wire logic [upp_pkg::UPP_NPORTS-1:0] port_power_req,
  input wire logic [upp_pkg::UPP_NPORTS-1:0] downstream_port_power_enable,
  input wire logic polarity_active_high
);
  import upp_pkg::*;
  wire logic [2:0] en = downstream_port_power_enable;
  wire logic s = upstream_bus_power_sense;
  wire logic pu = upstream_dp_pullup_en;
  wire logic pah = polarity_active_high;
  default clocking @(posedge clk); endclocking
  property p_pu; disable iff (reset) pu |-> s; endproperty
  a_pu: assert property (p_pu) else $error("pullup without power");
  property p_att; disable iff (reset) s[*6] |-> pu; endproperty
  a_att: assert property (p_att) else $error("no connect");
  property p_rst; reset |-> en == ~{3{port_power_polarity_strap}}; endproperty
  a_rst: assert property (p_rst) else $error("enable in reset");
  property p_on; disable iff (reset) !$past(reset) && !$past(reset, 2)
    |-> en == ($past(port_power_req) ~^ {3{pah}}); endproperty
  a_on: assert property (p_on) else $error("enable level");
  property p_hold; disable iff (reset) !$past(reset) && !$past(reset, 2)
    |-> $stable(pah); endproperty
  a_hold: assert property (p_hold) else $error("polarity moved");
  property p_cap; disable iff (reset) $past(reset, 2) && !$past(reset)
    |-> pah == $past(port_power_polarity_strap); endproperty
  a_cap: assert property (p_cap) else $error("strap not held");
  property p_rpol; reset |=> pah == UPP_POL_RST; endproperty
  a_rpol: assert property (p_rpol) else $error("reset polarity");
endmodule
bind upp_top upp_asserts i_chk (.clk, .reset, .upstream_bus_power_sense,
  .upstream_dp_pullup_en, .port_power_polarity_strap, .port_power_req,
  .downstream_port_power_enable, .polarity_active_high);

// >>> dv/upp_sw_model.sv
// Downstream power switch model
`timescale 1ns/1ps
module upp_sw_model (
  input wire logic active_high,
  input wire logic [2:0] enable,
  output logic [2:0] powered
);
  assign powered = active_high ? enable : ~enable;
endmodule

// >>> dv/tb_top.sv
// Self-checking bench for the port power block
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'h0, reset = 1'h1, sense = 1'h0, strap = 1'h1, pol = 1'h1;
  logic pu, pah;
  logic [2:0] req = 3'h0, en, pwr;
  int error_cnt = 0, tests_run = 0, cyc = 0;
  always #2 clk = ~clk;
  upp_top i_dut (.clk(clk), .reset(reset), .upstream_bus_power_sense(sense),
    .upstream_dp_pullup_en(pu), .port_power_polarity_strap(strap),
    .port_power_req(req), .downstream_port_power_enable(en),
    .polarity_active_high(pah));
  upp_sw_model i_sw (.active_high(pol), .enable(en), .powered(pwr));
  // Enable pin levels for a request word under a given polarity
  function automatic logic [2:0] exp_en(logic ah, logic [2:0] r);
    return ah ? r : ~r;
  endfunction
  task automatic chk(string n, logic [2:0] s, logic [2:0] e);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 500) begin
      error_cnt++;
      conclude();
    end
  end
  initial begin
    void'($urandom(36263));
    repeat (3) @(posedge clk);
    reset <= 1'h0;
    for (int p = 0; p < 2; p++) begin
      @(posedge clk);
      reset <= 1'h1;
      strap <= p[0];
      pol <= p[0];
      @(posedge clk);
      sense <= 1'h1;
      req <= 3'h7;
      @(posedge clk);
      @(negedge clk);
      chk("rst_en", en, exp_en(p[0], 3'h0));
      chk("rst_pu", 3'(pu), 3'h0);
      @(posedge clk);
      strap <= ~p[0];
      @(negedge clk);
      chk("rst_live", en, {3{p[0]}});
      @(posedge clk);
      strap <= p[0];
      reset <= 1'h0;
      sense <= 1'h0;
      repeat (2) @(posedge clk);
      for (int i = 0; i < 20; i++) begin
        @(posedge clk);
        req <= 3'($urandom);
        strap <= 1'($urandom);
        @(posedge clk);
        @(negedge clk);
        chk("en", en, exp_en(p[0], req));
        chk("pwr", pwr, req);
        chk("pol", 3'(pah), 3'(p[0]));
      end
      @(posedge clk);
      sense <= 1'h1;
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk("early", 3'(pu), 3'h0);
      @(posedge clk);
      @(negedge clk);
      chk("att", 3'(pu), 3'h1);
      @(posedge clk);
      sense <= 1'h0;
      @(negedge clk);
      chk("det", 3'(pu), 3'h0);
      $display("test pol %0d done", p);
    end
    conclude();
  end
endmodule
